// ===== fsar_pkg.sv
// Package for the strobe/converter control and fault flag register bank.
// Assumes a byte-wide register port driven by the serial control interface.
package fsar_pkg;
   localparam logic [7:0] ADDR_CTRL      = 8'h07;
   localparam logic [7:0] ADDR_FAULT     = 8'h08;
   localparam int         CH_LSB         = 0;
   localparam int         CH_W           = 4;
   localparam int         BIT_CONVERT    = 4;
   localparam int         BIT_SKIP       = 5;
   localparam int         BIT_TRIG_LEVEL = 6;
   localparam int         BIT_TRIG_EN    = 7;
   localparam int         BIT_UV         = 0;
   localparam int         BIT_RSVD       = 1;
   localparam int         BIT_NTC        = 2;
   localparam int         BIT_TXMASK     = 3;
   localparam int         BIT_TIMEOUT    = 4;
   localparam logic [3:0] CH_THERMISTOR  = 4'h0;
   localparam logic [3:0] CH_JUNCTION    = 4'h1;
   localparam logic [3:0] CH_SUPPLY      = 4'h2;
   localparam logic [7:0] CTRL_RESET     = 8'hE0;
   localparam logic [7:0] FAULT_RESET    = 8'h00;
endpackage

// ===== fsar_regs.sv
// Control register (converter channel, start, pulse-skip, trigger mode) and
// read-self-clear fault flag register of an LED flash driver.
// Assumes the serial interface gives one-cycle write/read strobes with address.
// Function
// [RL1] Channel select in bits 3:0 resets zero; 0 thermistor, 1 junction, 2 supply.
// [RL2] Writing one to bit 4 starts conversion; cleared by device on completion.
// [RL3] Start bit reads zero once conversion has finished; host may poll it.
// [RL4] Pulse-skip permit bit 5 resets one; zero forces fixed-frequency switching.
// [RL5] Trigger sensitivity bit 6 resets one; zero edge, one level.
// [RL6] Trigger enable bit 7 resets one; zero ignores trigger input.
// [RL7] Fault bit 0 resets zero, set on undervoltage event.
// [RL8] Fault bit 1 reserved, always reads zero.
// [RL9] Fault bit 2 resets zero, set on LED overtemperature trip.
// [RL10] Fault bit 3 resets zero, set on transmit-mask event during flash.
// [RL11] Fault bit 4 resets zero, set on flash timeout.
// [RL12] Fault flags hold until read, then clear automatically.
// [RL13] Host writes only defined channel codes; others reserved.
`timescale 1ns/10ps
module fsar_regs (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   input  wire logic       i_conv_done,
   input  wire logic       i_evt_uv,
   input  wire logic       i_evt_ntc,
   input  wire logic       i_evt_txmask,
   input  wire logic       i_evt_timeout,
   input  wire logic       i_trigger,
   output logic      [3:0] o_channel,
   output logic            o_conv_start,
   output logic            o_conv_busy,
   output logic            o_skip_permit,
   output logic            o_flash_trigger
);
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [4:0] fault_reg;
   logic [4:0] fault_next;
   logic       trig_reg;
   logic [7:0] rdata_next;
   logic       conv_start_reg;

   wire        sel_ctrl   = (i_addr == fsar_pkg::ADDR_CTRL);
   wire        sel_fault  = (i_addr == fsar_pkg::ADDR_FAULT);
   wire        wr_ctrl    = i_wr && sel_ctrl;
   wire        rd_fault   = i_rd && sel_fault;
   wire        start_req  = wr_ctrl && i_wdata[fsar_pkg::BIT_CONVERT]
                            && !ctrl_reg[fsar_pkg::BIT_CONVERT];
   // [RL7] [RL9] [RL10] [RL11] each event lands on its own flag bit
   wire [4:0]  fault_evt  = {i_evt_timeout, i_evt_txmask, i_evt_ntc, 1'b0, i_evt_uv};

   // [RL2] [RL3] busy bit held until completion clears it
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = i_wdata;
         // A busy conversion cannot be cancelled by writing zero
         ctrl_next[fsar_pkg::BIT_CONVERT] = ctrl_reg[fsar_pkg::BIT_CONVERT]
                                            | i_wdata[fsar_pkg::BIT_CONVERT];
      end
      if (i_conv_done && !start_req) begin
         ctrl_next[fsar_pkg::BIT_CONVERT] = 1'b0;
      end
   end

   // [RL12] Read clears; a same-cycle event wins over the clear
   genvar fb;
   generate
      for (fb = 0; fb < 5; fb++) begin : g_fault
         assign fault_next[fb] = (fault_reg[fb] && !rd_fault) || fault_evt[fb];
      end
   endgenerate

   // [RL8] reserved bit forced to zero
   assign rdata_next = sel_ctrl  ? ctrl_reg :
                       sel_fault ? {3'h0, fault_reg[4:2], 1'b0, fault_reg[0]} : 8'h00;

   // [RL1] [RL4] [RL5] [RL6] reset values
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ctrl_reg       <= fsar_pkg::CTRL_RESET;
         fault_reg      <= fsar_pkg::FAULT_RESET[4:0];
         trig_reg       <= 1'b0;
         o_rdata        <= 8'h00;
         conv_start_reg <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         fault_reg      <= fault_next;
         trig_reg       <= i_trigger;
         o_rdata        <= i_rd ? rdata_next : o_rdata;
         conv_start_reg <= start_req;
      end
   end

   // [RL6] [RL5] trigger gated by enable, edge or level
   wire trig_edge = i_trigger && !trig_reg;
   assign o_flash_trigger = ctrl_reg[fsar_pkg::BIT_TRIG_EN] &&
                            (ctrl_reg[fsar_pkg::BIT_TRIG_LEVEL] ? i_trigger : trig_edge);

   assign o_channel     = ctrl_reg[fsar_pkg::CH_LSB +: fsar_pkg::CH_W];
   assign o_conv_start  = conv_start_reg;
   assign o_conv_busy   = ctrl_reg[fsar_pkg::BIT_CONVERT];
   // [RL4] zero forces fixed-frequency switching
   assign o_skip_permit = ctrl_reg[fsar_pkg::BIT_SKIP];

   // Reset values, checked without a disable so the reset edge itself is seen
   chk_reset_ctrl: assert property (@(posedge i_clock) // [RL1] [RL4] [RL5] [RL6]
      !i_rst_n
      |=> ctrl_reg == fsar_pkg::CTRL_RESET)
      else $error("control register reset value wrong");

   chk_reset_faults: assert property (@(posedge i_clock) // [RL7] [RL9] [RL10] [RL11]
      !i_rst_n
      |=> fault_reg == fsar_pkg::FAULT_RESET[4:0])
      else $error("fault flags not cleared by reset");

   chk_reset_outputs: assert property (@(posedge i_clock)
      !i_rst_n
      |=> o_rdata == 8'h00 && !o_conv_start)
      else $error("read data or start pulse not reset");

   chk_reset_channel: assert property (@(posedge i_clock) // [RL1]
      !i_rst_n
      |=> o_channel == fsar_pkg::CH_THERMISTOR)
      else $error("channel select not reset to thermistor");

   // Control fields follow the written byte
   chk_channel_write: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL1]
      wr_ctrl
      |=> o_channel == $past(i_wdata[fsar_pkg::CH_LSB +: fsar_pkg::CH_W]))
      else $error("channel select not taken from write");

   chk_skip_write: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL4]
      wr_ctrl
      |=> o_skip_permit == $past(i_wdata[fsar_pkg::BIT_SKIP]))
      else $error("pulse-skip permit not taken from write");

   chk_type_write: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL5]
      wr_ctrl
      |=> ctrl_reg[fsar_pkg::BIT_TRIG_LEVEL] == $past(i_wdata[fsar_pkg::BIT_TRIG_LEVEL]))
      else $error("trigger sensitivity not taken from write");

   chk_enable_write: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL6]
      wr_ctrl
      |=> ctrl_reg[fsar_pkg::BIT_TRIG_EN] == $past(i_wdata[fsar_pkg::BIT_TRIG_EN]))
      else $error("trigger enable not taken from write");

   chk_ctrl_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !wr_ctrl && !i_conv_done
      |=> ctrl_reg == $past(ctrl_reg))
      else $error("control register changed without cause");

   chk_done_keeps: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL2]
      i_conv_done && !wr_ctrl
      |=> o_channel == $past(o_channel) && o_skip_permit == $past(o_skip_permit))
      else $error("completion disturbed other control fields");

   chk_other_writes: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_wr && !sel_ctrl && !i_conv_done
      |=> ctrl_reg == $past(ctrl_reg))
      else $error("write to another address changed control");

   // Conversion start and busy bit
   chk_start_sets_busy: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL2]
      start_req
      |=> o_conv_busy && o_conv_start)
      else $error("conversion start not latched");

   chk_done_clears_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL3]
      i_conv_done && !start_req
      |=> !o_conv_busy)
      else $error("start bit not cleared on completion");

   chk_start_one_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL2]
      o_conv_start
      |=> !o_conv_start)
      else $error("start pulse longer than one cycle");

   chk_start_cause: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL2]
      o_conv_start
      |-> $past(wr_ctrl) && $past(i_wdata[fsar_pkg::BIT_CONVERT]))
      else $error("start pulse without a start write");

   chk_no_restart: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL2]
      o_conv_busy
      |=> !o_conv_start)
      else $error("new start pulse while busy");

   chk_busy_no_cancel: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL2]
      o_conv_busy && !i_conv_done
      |=> o_conv_busy)
      else $error("busy bit dropped before completion");

   chk_start_wins: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL2]
      start_req && i_conv_done
      |=> o_conv_busy)
      else $error("completion cancelled a new start");

   chk_idle_stays: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL3]
      !o_conv_busy && !start_req
      |=> !o_conv_busy)
      else $error("busy bit rose without a start");

   chk_busy_reads: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL3]
      i_rd && sel_ctrl
      |=> o_rdata[fsar_pkg::BIT_CONVERT] == $past(o_conv_busy))
      else $error("start bit read back wrong");

   // Read path
   chk_ctrl_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_rd && sel_ctrl
      |=> o_rdata == $past(ctrl_reg))
      else $error("control read data wrong");

   chk_fault_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL7] [RL9]
      rd_fault
      |=> o_rdata[4:2] == $past(fault_reg[4:2]) && o_rdata[0] == $past(fault_reg[0]))
      else $error("fault read data wrong");

   chk_fault_upper: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      rd_fault
      |=> o_rdata[7:5] == 3'h0)
      else $error("unimplemented fault bits read nonzero");

   chk_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL8]
      $past(i_rd) && $past(sel_fault)
      |-> !o_rdata[1])
      else $error("reserved fault bit read nonzero");

   chk_unmapped_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_rd && !sel_ctrl && !sel_fault
      |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");

   chk_rdata_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !i_rd
      |=> $stable(o_rdata))
      else $error("read data changed without a read");

   // Fault flags
   chk_uv_sets_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL7]
      i_evt_uv
      |=> fault_reg[0])
      else $error("undervoltage flag not set");

   chk_ntc_sets_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL9]
      i_evt_ntc
      |=> fault_reg[2])
      else $error("overtemperature flag not set");

   chk_txmask_sets_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL10]
      i_evt_txmask
      |=> fault_reg[3])
      else $error("transmit-mask flag not set");

   chk_timeout_sets_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL11]
      i_evt_timeout
      |=> fault_reg[4])
      else $error("timeout flag not set");

   chk_read_clears_flags: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL12]
      rd_fault && fault_evt == 5'h00
      |=> fault_reg == 5'h00)
      else $error("fault flags not cleared after read");

   chk_flags_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL12]
      !rd_fault
      |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
      else $error("fault flag lost without read");

   chk_read_keeps_new: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL12]
      rd_fault
      |=> fault_reg == $past(fault_evt))
      else $error("event during clearing read lost");

   chk_reserved_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL8]
      1'b1
      |-> !fault_reg[fsar_pkg::BIT_RSVD])
      else $error("reserved flag bit set");

   chk_uv_needs_event: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL7]
      !fault_reg[0] && !i_evt_uv
      |=> !fault_reg[0])
      else $error("undervoltage flag set without event");

   chk_tmo_needs_event: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL11]
      !fault_reg[4] && !i_evt_timeout
      |=> !fault_reg[4])
      else $error("timeout flag set without event");

   chk_fault_wr_ignored: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_wr && sel_fault && !rd_fault
      |=> fault_reg == ($past(fault_reg) | $past(fault_evt)))
      else $error("write changed fault flags");

   // Flash trigger gating
   chk_trigger_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL6]
      !ctrl_reg[fsar_pkg::BIT_TRIG_EN]
      |-> !o_flash_trigger)
      else $error("trigger passed while disabled");

   chk_level_trigger: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL5]
      ctrl_reg[fsar_pkg::BIT_TRIG_EN] && ctrl_reg[fsar_pkg::BIT_TRIG_LEVEL]
      |-> o_flash_trigger == i_trigger)
      else $error("level trigger mismatch");

   chk_edge_fires: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL5]
      ctrl_reg[7] && !ctrl_reg[6] && i_trigger && !$past(i_trigger)
      |-> o_flash_trigger)
      else $error("rising trigger edge missed");

   chk_edge_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL5]
      !ctrl_reg[6] && $past(i_trigger) && $past(i_rst_n)
      |-> !o_flash_trigger)
      else $error("edge mode fired on a held level");

   chk_trigger_low: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RL5]
      !i_trigger
      |-> !o_flash_trigger)
      else $error("trigger output without trigger input");

endmodule

// ===== fsar_conv_model.sv
// Behavioural converter that answers each start pulse with a completion pulse.
// Assumes start is a one-cycle registered pulse on the rising edge.
`timescale 1ns/10ps
module fsar_conv_model #(parameter int LAT = 5) (
   input  wire logic i_clock,
   input  wire logic i_start,
   output logic      o_done
);
   initial begin
      o_done = 1'b0;
      forever begin
         @(posedge i_clock);
         #2;
         if (i_start) begin
            repeat (LAT) @(posedge i_clock);
            #1 o_done = 1'b1;
            @(posedge i_clock);
            #1 o_done = 1'b0;
         end
      end
   end
endmodule

// ===== flash_strobe_adc_fault_regs_bench.sv
// Self-checking bench for the control and fault flag registers.
// Assumes the converter model and one-cycle read/write strobes.
`timescale 1ns/10ps
module flash_strobe_adc_fault_regs_bench;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, uv = 0, ntc = 0, txm = 0, tmo = 0, trig = 0, done;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [3:0] ch;
   logic       start, busy, skip, ftrig;
   int         failures = 0, cmp_count = 0;
   fsar_regs DUT (.i_clock(clk), .i_rst_n(rst_n), .i_wr(wr), .i_rd(rd), .i_addr(addr),
      .i_wdata(wdata), .o_rdata(rdata), .i_conv_done(done), .i_evt_uv(uv), .i_evt_ntc(ntc),
      .i_evt_txmask(txm), .i_evt_timeout(tmo), .i_trigger(trig), .o_channel(ch),
      .o_conv_start(start), .o_conv_busy(busy), .o_skip_permit(skip), .o_flash_trigger(ftrig));
   fsar_conv_model CONV (.i_clock(clk), .i_start(start), .o_done(done));
   initial forever #20 clk = ~clk;
   task automatic conclude();
      if (failures == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk); #1 wr = 1; addr = a; wdata = d;
      @(posedge clk); #1 wr = 0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk); #1 rd = 1; addr = a;
      @(posedge clk); #1 rd = 0;
      chk(rdata, exp);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 rst_n = 1;
      rreg(fsar_pkg::ADDR_CTRL, 8'hE0);
      rreg(fsar_pkg::ADDR_FAULT, 8'h00);
      chk({7'h00, skip}, 8'h01);
      @(posedge clk); #1 {uv, ntc, txm, tmo} = 4'hF;
      @(posedge clk); #1 {uv, ntc, txm, tmo} = 4'h0;
      repeat (3) @(posedge clk);
      rreg(fsar_pkg::ADDR_FAULT, 8'h1D);
      rreg(fsar_pkg::ADDR_FAULT, 8'h00);
      wreg(fsar_pkg::ADDR_FAULT, 8'hFF);
      rreg(fsar_pkg::ADDR_FAULT, 8'h00);
      for (int c = 0; c < 3; c++) begin
         wreg(fsar_pkg::ADDR_CTRL, 8'(c));
         chk({4'h0, ch}, 8'(c));
         chk({7'h00, skip}, 8'h00);
      end
      wreg(fsar_pkg::ADDR_CTRL, 8'h12);
      chk({7'h00, start}, 8'h01);
      chk({7'h00, busy}, 8'h01);
      wreg(fsar_pkg::ADDR_CTRL, 8'h12);
      chk({7'h00, start}, 8'h00);
      rreg(fsar_pkg::ADDR_CTRL, 8'h12);
      for (int n = 0; busy && n < 50; n++) @(posedge clk);
      #1 if (busy !== 1'b0) begin failures++; $display("[FAIL] %0t busy stuck", $time); conclude(); end
      rreg(fsar_pkg::ADDR_CTRL, 8'h02);
      rreg(8'h00, 8'h00);
      // Event in the same cycle as the clearing read must survive it
      @(posedge clk); #1 rd = 1; addr = fsar_pkg::ADDR_FAULT; uv = 1;
      @(posedge clk); #1 rd = 0; uv = 0;
      chk(rdata, 8'h00);
      rreg(fsar_pkg::ADDR_FAULT, 8'h01);
      wreg(fsar_pkg::ADDR_CTRL, 8'hC0);
      trig = 1;
      #1 chk({7'h00, ftrig}, 8'h01);
      wreg(fsar_pkg::ADDR_CTRL, 8'h40);
      chk({7'h00, ftrig}, 8'h00);
      wreg(fsar_pkg::ADDR_CTRL, 8'h80);
      trig = 0;
      @(posedge clk); #1 trig = 1;
      #1 chk({7'h00, ftrig}, 8'h01);
      @(posedge clk); #1 chk({7'h00, ftrig}, 8'h00);
      // Mid-run reset with a flag pending
      @(posedge clk); #1 tmo = 1;
      @(posedge clk); #1 tmo = 0; rst_n = 0; trig = 0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      rreg(fsar_pkg::ADDR_FAULT, 8'h00);
      rreg(fsar_pkg::ADDR_CTRL, 8'hE0);
      conclude();
   end
endmodule
